//--- bis_sequencer.sv
// Function
// - Idle standby: standby lamp only, others off
// - Heat demand switches circulator on
// - Two second self check, then blower
// - Pre-purge waits for airflow switch closed
// - Airflow proved: purge lamp, 15 s purge
// - Then purge lamp off, igniter 20 s
// - Then gas valve, gas lamp, 6 s trial
// - Igniter and its lamp off after 2 s
// - Flame proving shows flame lamp dim
// - Flame judged only in last 2 s
// - Proven flame drives flame lamp full
// - Demand end: gas, circulator off, 30 s purge
// - After post-purge blower off, back to standby
// - No flame: gas valve and lamp off
module bis_sequencer #(
  parameter int TICK_CYC = bis_pkg::TICK_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       heat_demand,
  input  wire logic       air_proved,
  input  wire logic       flame_sense,
  output logic            circ_on,
  output logic            blower_on,
  output logic            igniter_on,
  output logic            gas_valve_on,
  output logic            lamp_standby,
  output logic            lamp_purge,
  output logic            lamp_igniter,
  output logic            lamp_gas,
  output logic [1:0]      lamp_flame
);
  typedef struct packed {
    bis_pkg::bis_state_t     state;
    logic [bis_pkg::TMR_W-1:0] tmr;
    logic                    circ;
    logic                    blower;
    logic                    igniter;
    logic                    gas;
    logic                    l_standby;
    logic                    l_purge;
    logic                    l_igniter;
    logic                    l_gas;
    logic [1:0]              l_flame;
  } bis_st_t;

  bis_st_t st_reg;
  bis_st_t st_next;
  logic    tick;

  // All intervals count ticks of this divider
  bis_tick #(
    .CYC (TICK_CYC)
  ) u_tick (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .tick    (tick)
  );

  // Timer restarts on every state change; done on the last tick of an interval
  function automatic logic tmr_done(input logic [bis_pkg::TMR_W-1:0] t,
                                    input logic [bis_pkg::TMR_W-1:0] n,
                                    input logic tk);
    tmr_done = tk && (t == n - 1'b1);
  endfunction

  // Sequence and outputs; outputs follow the next state so they align with it
  always_comb
  begin
    st_next = st_reg;
    if (tick)
      st_next.tmr = st_reg.tmr + 1'b1;
    case (st_reg.state)
      bis_pkg::S_OFF:
        st_next.state = bis_pkg::S_STANDBY;
      bis_pkg::S_STANDBY:
        if (heat_demand)
          st_next.state = bis_pkg::S_SELFCHK;
      bis_pkg::S_SELFCHK:
        if (!heat_demand)
          st_next.state = bis_pkg::S_POSTPURGE;
        else if (tmr_done(st_reg.tmr, bis_pkg::SELF_CHECK_TK, tick))
          st_next.state = bis_pkg::S_AIRWAIT;
      bis_pkg::S_AIRWAIT:
        if (!heat_demand)
          st_next.state = bis_pkg::S_POSTPURGE;
        else if (air_proved)
          st_next.state = bis_pkg::S_PREPURGE;
      bis_pkg::S_PREPURGE:
        if (!heat_demand)
          st_next.state = bis_pkg::S_POSTPURGE;
        else if (tmr_done(st_reg.tmr, bis_pkg::PREPURGE_TK, tick))
          st_next.state = bis_pkg::S_WARMUP;
      bis_pkg::S_WARMUP:
        if (!heat_demand)
          st_next.state = bis_pkg::S_POSTPURGE;
        else if (tmr_done(st_reg.tmr, bis_pkg::WARMUP_TK, tick))
          st_next.state = bis_pkg::S_TRIAL;
      bis_pkg::S_TRIAL:
        // Flame before the proving window is ignored: igniter glow can fake it
        if (!heat_demand)
          st_next.state = bis_pkg::S_POSTPURGE;
        else if (flame_sense && st_reg.tmr >= bis_pkg::PROVE_START_TK)
          st_next.state = bis_pkg::S_RUN;
        else if (tmr_done(st_reg.tmr, bis_pkg::TRIAL_TK, tick))
          st_next.state = bis_pkg::S_FAIL;
      bis_pkg::S_RUN:
        if (!heat_demand)
          st_next.state = bis_pkg::S_POSTPURGE;
      bis_pkg::S_FAIL:
        // Lockout holds until the thermostat releases the call
        if (!heat_demand)
          st_next.state = bis_pkg::S_POSTPURGE;
      bis_pkg::S_POSTPURGE:
        if (tmr_done(st_reg.tmr, bis_pkg::POSTPURGE_TK, tick))
          st_next.state = bis_pkg::S_STANDBY;
      default:
        st_next.state = bis_pkg::S_OFF;
    endcase
    if (st_next.state != st_reg.state)
      st_next.tmr = '0;

    // Output decode from the next state
    st_next.circ      = 1'b0;
    st_next.blower    = 1'b0;
    st_next.igniter   = 1'b0;
    st_next.gas       = 1'b0;
    st_next.l_standby = 1'b0;
    st_next.l_purge   = 1'b0;
    st_next.l_igniter = 1'b0;
    st_next.l_gas     = 1'b0;
    st_next.l_flame   = bis_pkg::FLAME_OFF;
    case (st_next.state)
      bis_pkg::S_STANDBY:
        st_next.l_standby = 1'b1;
      bis_pkg::S_SELFCHK:
      begin
        st_next.l_standby = 1'b1;
        st_next.circ      = 1'b1;
      end
      bis_pkg::S_AIRWAIT:
      begin
        st_next.l_standby = 1'b1;
        st_next.circ      = 1'b1;
        st_next.blower    = 1'b1;
      end
      bis_pkg::S_PREPURGE:
      begin
        st_next.l_standby = 1'b1;
        st_next.circ      = 1'b1;
        st_next.blower    = 1'b1;
        st_next.l_purge   = 1'b1;
      end
      bis_pkg::S_WARMUP:
      begin
        st_next.l_standby = 1'b1;
        st_next.circ      = 1'b1;
        st_next.blower    = 1'b1;
        st_next.igniter   = 1'b1;
        st_next.l_igniter = 1'b1;
      end
      bis_pkg::S_TRIAL:
      begin
        st_next.l_standby = 1'b1;
        st_next.circ      = 1'b1;
        st_next.blower    = 1'b1;
        st_next.gas       = 1'b1;
        st_next.l_gas     = 1'b1;
        st_next.igniter   = st_next.tmr < bis_pkg::IGN_OFF_TK;
        st_next.l_igniter = st_next.tmr < bis_pkg::IGN_OFF_TK;
        if (st_next.tmr >= bis_pkg::IGN_OFF_TK)
          st_next.l_flame = bis_pkg::FLAME_LOW;
      end
      bis_pkg::S_RUN:
      begin
        st_next.l_standby = 1'b1;
        st_next.circ      = 1'b1;
        st_next.blower    = 1'b1;
        st_next.gas       = 1'b1;
        st_next.l_gas     = 1'b1;
        st_next.l_flame   = bis_pkg::FLAME_FULL;
      end
      bis_pkg::S_FAIL:
      begin
        st_next.l_standby = 1'b1;
        st_next.circ      = 1'b1; // Gas and gas lamp stay off
      end
      bis_pkg::S_POSTPURGE:
      begin
        st_next.l_standby = 1'b1;
        st_next.blower    = 1'b1;
        st_next.l_purge   = 1'b1;
        // Flame lamp lingers while the gas left in the blower burns off
        if (st_reg.state == bis_pkg::S_RUN ||
            (st_reg.state == bis_pkg::S_POSTPURGE &&
             st_reg.l_flame == bis_pkg::FLAME_FULL &&
             st_next.tmr < bis_pkg::FLAME_TAIL_TK))
          st_next.l_flame = bis_pkg::FLAME_FULL;
      end
      default:
        st_next.l_flame = bis_pkg::FLAME_OFF;
    endcase
  end

  // Reset leaves every output off until standby is entered
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign circ_on      = st_reg.circ;
  assign blower_on    = st_reg.blower;
  assign igniter_on   = st_reg.igniter;
  assign gas_valve_on = st_reg.gas;
  assign lamp_standby = st_reg.l_standby;
  assign lamp_purge   = st_reg.l_purge;
  assign lamp_igniter = st_reg.l_igniter;
  assign lamp_gas     = st_reg.l_gas;
  assign lamp_flame   = st_reg.l_flame;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_in_run_demand_drop;
    st_reg.state == bis_pkg::S_RUN && !heat_demand;
  endsequence

  sequence s_postpurge_entry;
    st_reg.state == bis_pkg::S_POSTPURGE && blower_on && !gas_valve_on && !circ_on
      && lamp_purge && !lamp_gas;
  endsequence

  property p_standby_lamps;
    st_reg.state == bis_pkg::S_STANDBY |-> lamp_standby && !lamp_purge && !lamp_igniter
      && !lamp_gas && lamp_flame == bis_pkg::FLAME_OFF && !blower_on && !gas_valve_on;
  endproperty
  a_standby_lamps: assert property (p_standby_lamps) else $error("standby lamps wrong");

  property p_demand_circ;
    st_reg.state == bis_pkg::S_STANDBY && heat_demand |=> circ_on && !blower_on;
  endproperty
  a_demand_circ: assert property (p_demand_circ) else $error("circulator not started");

  property p_selfcheck_blower;
    $rose(blower_on) && st_reg.state == bis_pkg::S_AIRWAIT
      |-> $past(st_reg.state) == bis_pkg::S_SELFCHK
      && $past(st_reg.tmr) == bis_pkg::SELF_CHECK_TK - 1'b1;
  endproperty
  a_selfcheck_blower: assert property (p_selfcheck_blower) else $error("blower early");

  property p_air_gate;
    $rose(lamp_purge) && st_reg.state == bis_pkg::S_PREPURGE |-> $past(air_proved);
  endproperty
  a_air_gate: assert property (p_air_gate) else $error("purge without airflow");

  property p_warmup_entry;
    $rose(igniter_on) |-> !lamp_purge && lamp_igniter
      && $past(st_reg.tmr) == bis_pkg::PREPURGE_TK - 1'b1;
  endproperty
  a_warmup_entry: assert property (p_warmup_entry) else $error("warmup entry wrong");

  property p_igniter_cut;
    st_reg.state == bis_pkg::S_TRIAL && st_reg.tmr >= bis_pkg::IGN_OFF_TK
      |-> !igniter_on && !lamp_igniter && gas_valve_on && lamp_flame == bis_pkg::FLAME_LOW;
  endproperty
  a_igniter_cut: assert property (p_igniter_cut) else $error("igniter not cut");

  property p_flame_window;
    $rose(lamp_flame == bis_pkg::FLAME_FULL) |-> $past(flame_sense)
      && $past(st_reg.tmr) >= bis_pkg::PROVE_START_TK;
  endproperty
  a_flame_window: assert property (p_flame_window) else $error("flame outside window");

  property p_demand_end;
    s_in_run_demand_drop |=> s_postpurge_entry;
  endproperty
  a_demand_end: assert property (p_demand_end) else $error("post-purge entry wrong");

  property p_no_flame;
    st_reg.state == bis_pkg::S_TRIAL && !flame_sense
      && st_reg.tmr == bis_pkg::TRIAL_TK - 1'b1 && tick && heat_demand
      |=> (!gas_valve_on && !lamp_gas) [*2];
  endproperty
  a_no_flame: assert property (p_no_flame) else $error("gas left open");

  property p_post_end;
    st_reg.state == bis_pkg::S_POSTPURGE && tick
      && st_reg.tmr == bis_pkg::POSTPURGE_TK - 1'b1 |=> !blower_on && lamp_standby;
  endproperty
  a_post_end: assert property (p_post_end) else $error("post-purge end wrong");
endmodule

//--- bis_pkg.sv
package bis_pkg;
  // Controller clock rate and the timer tick derived from it
  localparam int CLK_HZ  = 25_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int TICK_W   = 15;

  // Sequence intervals in milliseconds
  localparam int SELF_CHECK_MS = 2000;
  localparam int PREPURGE_MS   = 15000;
  localparam int WARMUP_MS     = 20000;
  localparam int TRIAL_MS      = 6000;
  localparam int IGN_OFF_MS    = 2000;
  localparam int PROVE_MS      = 2000;
  localparam int POSTPURGE_MS  = 30000;
  localparam int FLAME_TAIL_MS = 2000;

  // Same intervals as counts of timer ticks
  localparam int TMR_W = 16;
  localparam logic [TMR_W-1:0] SELF_CHECK_TK = TMR_W'(SELF_CHECK_MS * 1000 / TICK_US);
  localparam logic [TMR_W-1:0] PREPURGE_TK   = TMR_W'(PREPURGE_MS * 1000 / TICK_US);
  localparam logic [TMR_W-1:0] WARMUP_TK     = TMR_W'(WARMUP_MS * 1000 / TICK_US);
  localparam logic [TMR_W-1:0] TRIAL_TK      = TMR_W'(TRIAL_MS * 1000 / TICK_US);
  localparam logic [TMR_W-1:0] IGN_OFF_TK    = TMR_W'(IGN_OFF_MS * 1000 / TICK_US);
  localparam logic [TMR_W-1:0] PROVE_START_TK =
    TMR_W'((TRIAL_MS - PROVE_MS) * 1000 / TICK_US);
  localparam logic [TMR_W-1:0] POSTPURGE_TK  = TMR_W'(POSTPURGE_MS * 1000 / TICK_US);
  localparam logic [TMR_W-1:0] FLAME_TAIL_TK = TMR_W'(FLAME_TAIL_MS * 1000 / TICK_US);

  // Flame lamp brightness levels
  localparam logic [1:0] FLAME_OFF  = 2'h0;
  localparam logic [1:0] FLAME_LOW  = 2'h1;
  localparam logic [1:0] FLAME_FULL = 2'h2;

  typedef enum logic [3:0] {
    S_OFF,
    S_STANDBY,
    S_SELFCHK,
    S_AIRWAIT,
    S_PREPURGE,
    S_WARMUP,
    S_TRIAL,
    S_RUN,
    S_FAIL,
    S_POSTPURGE
  } bis_state_t;
endpackage

//--- bis_tick.sv
module bis_tick #(
  parameter int CYC = bis_pkg::TICK_CYC
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  output logic      tick
);
  typedef struct packed {
    logic [bis_pkg::TICK_W-1:0] cnt;
    logic                       tick;
  } bis_tick_st_t;

  bis_tick_st_t st_reg;
  bis_tick_st_t st_next;

  localparam logic [bis_pkg::TICK_W-1:0] LAST = bis_pkg::TICK_W'(CYC - 1);

  // Free-running divider; one-cycle enable every CYC clocks
  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == LAST)
    begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tick = st_reg.tick;
endmodule

//--- bis_plant.sv
// Far side of the sequencer: air proving switch and flame sensor
module bis_plant
(
  input  wire logic blower_on,
  input  wire logic gas_valve_on,
  input  wire logic air_en,
  input  wire logic flame_en,
  output logic      air_proved,
  output logic      flame_sense
);
  timeunit 1ns;
  timeprecision 1ps;

  // Switch is normally open, so it reads 0 unless the blower moves air
  assign air_proved  = blower_on & air_en;
  // No gas means no flame; a flame fault is only what the bench asks for
  assign flame_sense = gas_valve_on & flame_en;
endmodule

//--- tb_burner_ignition_sequencer.sv
module tb_burner_ignition_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk     = 1'b0;
  logic       resetn      = 1'b0;
  logic       heat_demand = 1'b0;
  logic       air_en      = 1'b0;
  logic       flame_en    = 1'b0;
  logic       air_proved;
  logic       flame_sense;
  logic       circ_on;
  logic       blower_on;
  logic       igniter_on;
  logic       gas_valve_on;
  logic       lamp_standby;
  logic       lamp_purge;
  logic       lamp_igniter;
  logic       lamp_gas;
  logic [1:0] lamp_flame;
  logic [9:0] o;
  int         errors   = 0;
  int         compares = 0;

  // One-cycle ticks keep the long fixed intervals within a sane run
  bis_sequencer #(.TICK_CYC(1)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .heat_demand(heat_demand),
    .air_proved(air_proved), .flame_sense(flame_sense), .circ_on(circ_on),
    .blower_on(blower_on), .igniter_on(igniter_on), .gas_valve_on(gas_valve_on),
    .lamp_standby(lamp_standby), .lamp_purge(lamp_purge), .lamp_igniter(lamp_igniter),
    .lamp_gas(lamp_gas), .lamp_flame(lamp_flame)
  );

  bis_plant u_plant (
    .blower_on(blower_on), .gas_valve_on(gas_valve_on), .air_en(air_en),
    .flame_en(flame_en), .air_proved(air_proved), .flame_sense(flame_sense)
  );

  always #20 sys_clk = ~sys_clk;

  // All outputs in one word so each step is judged whole
  assign o = {lamp_flame, lamp_gas, lamp_igniter, lamp_purge, lamp_standby,
              gas_valve_on, igniter_on, blower_on, circ_on};

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for output bit i to reach v; with one-cycle ticks the wait is exact
  task automatic wt(input int i, input logic v, input int n);
    int c;
    c = 0;
    while (o[i] !== v && c < n + 20)
    begin
      @(negedge sys_clk);
      c++;
    end
    chk(16'(c), 16'(n));
  endtask

  task automatic t_reset();
    resetn = 1'b0;
    heat_demand = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(16'(o), 16'h0000);
    resetn = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(16'(o), 16'h0010);
  endtask

  // Common start-up up to the igniter warm-up
  task automatic start_up();
    air_en = 1'b0;
    heat_demand = 1'b1;
    @(negedge sys_clk);
    chk(16'(o), 16'h0011);
    wt(1, 1'b1, bis_pkg::SELF_CHECK_MS);
    chk(16'(o), 16'h0013);
    repeat (100) @(negedge sys_clk);
    chk(16'(o), 16'h0013);
    air_en = 1'b1;
    wt(5, 1'b1, 1);
    chk(16'(o), 16'h0033);
    wt(5, 1'b0, bis_pkg::PREPURGE_MS);
    chk(16'(o), 16'h0057);
  endtask

  task automatic t_good_run();
    flame_en = 1'b1;
    start_up();
    wt(3, 1'b1, bis_pkg::WARMUP_MS);
    chk(16'(o), 16'h00df);
    wt(2, 1'b0, bis_pkg::IGN_OFF_MS);
    chk(16'(o), 16'h019b);
    // Flame is present early; it is taken one edge after the last window opens
    wt(9, 1'b1, bis_pkg::TRIAL_MS - bis_pkg::PROVE_MS - bis_pkg::IGN_OFF_MS + 1);
    chk(16'(o), 16'h029b);
    heat_demand = 1'b0;
    @(negedge sys_clk);
    chk(16'(o), 16'h0232);
    wt(9, 1'b0, bis_pkg::FLAME_TAIL_MS);
    chk(16'(o), 16'h0032);
    wt(5, 1'b0, bis_pkg::POSTPURGE_MS - bis_pkg::FLAME_TAIL_MS);
    chk(16'(o), 16'h0010);
  endtask

  task automatic t_no_flame();
    flame_en = 1'b0;
    start_up();
    wt(3, 1'b1, bis_pkg::WARMUP_MS);
    wt(3, 1'b0, bis_pkg::TRIAL_MS);
    chk(16'(o), 16'h0011);
    // Lockout only ends when the call for heat is withdrawn
    heat_demand = 1'b0;
    @(negedge sys_clk);
    chk(16'(o), 16'h0032);
  endtask

  // Abort in the self check; a later abort would first cost the start-up intervals of run time
  task automatic t_abort();
    heat_demand = 1'b1;
    @(negedge sys_clk);
    chk(16'(o), 16'h0011);
    heat_demand = 1'b0;
    @(negedge sys_clk);
    chk(16'(o), 16'h0032);
  endtask

  task automatic results();
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    t_reset();
    t_good_run();
    t_no_flame();
    t_reset();
    t_abort();
    results();
  end

  // Run takes about 114k cycles; this cuts a hang short soon after
  initial
  begin
    repeat (125000) @(negedge sys_clk);
    errors++;
    results();
  end
endmodule
